// ---- design/gdic_defs.vh ----
// Function
// - While active short enable is high the PWM command is ignored and the output follows the active short level.
// - Under active short, a high level drives the high side output and a low level turns on the low side pull-down.
// - With the driver enabled and no override, a high PWM command drives the high side and a low one the low side.
// - Shoot-through fault is raised whenever the positive and negative PWM inputs are high together.
// - Fault alarm goes low on any unmasked assigned fault and stays high when all are absent or masked.
// - Fault warning, in its indicator role, goes low on any unmasked assigned fault and is high otherwise.
// - In the alternate role, fault warning carries a PWM whose duty cycle follows the selected ADC value.
`ifndef GDIC_DEFS_VH
`define GDIC_DEFS_VH
`define GDIC_CLK_HZ 20000000
`define GDIC_PWM_MIN_HZ 1000
`define GDIC_PWM_MAX_HZ 50000
`define GDIC_FAULT_W 8
`define GDIC_ADC_W 10
`define GDIC_STP_BIT 0
`define GDIC_SYNC_RST 4'h0
`define GDIC_HS_RST 1'b0
`define GDIC_LS_RST 1'b1
`define GDIC_STP_RST 1'b0
`define GDIC_ALARM_RST 1'b1
`define GDIC_WARN_RST 1'b1
`endif

// ---- design/gdic_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "gdic_defs.vh"
module gdic_top #(
    parameter FAULT_W = `GDIC_FAULT_W,
    parameter ADC_W = `GDIC_ADC_W
) (
    input wire clk_in,
    input wire srst_in,
    input wire pwm_positive_in,
    input wire pwm_negative_in,
    input wire active_short_enable_in,
    input wire active_short_level_in,
    input wire driver_enable_in,
    input wire [FAULT_W-1:0] fault_event_in,
    input wire [FAULT_W-1:0] alarm_mask_in,
    input wire [FAULT_W-1:0] warning_mask_in,
    input wire duty_mode_in,
    input wire [ADC_W-1:0] adc_value_in,
    output reg high_side_output_out,
    output reg low_side_output_out,
    output reg shoot_through_fault_out,
    output reg fault_alarm_n_out,
    output reg fault_warning_n_out
);
    localparam [3:0] SYNC_RST = `GDIC_SYNC_RST;
    localparam [ADC_W-1:0] DUTY_STEP = {{(ADC_W-1){1'b0}}, 1'b1};
    localparam [ADC_W-1:0] DUTY_ZERO = {ADC_W{1'b0}};

    // Pin order in the synchroniser: positive PWM, negative PWM, override enable, level.
    wire [3:0] pins_raw;
    reg [3:0] sync_a;
    reg [3:0] sync_b;
    reg [ADC_W-1:0] duty_cnt;
    reg [ADC_W-1:0] next_duty_cnt;
    reg [ADC_W-1:0] duty_level;
    reg [ADC_W-1:0] next_duty_level;
    wire pwm_p;
    wire pwm_n;
    wire active_short_enable;
    wire asc_lvl;
    wire duty_wrap;
    wire [FAULT_W-1:0] stp_vec;
    wire [FAULT_W-1:0] faults;
    wire [FAULT_W-1:0] alarm_hits;
    wire [FAULT_W-1:0] warning_hits;
    reg next_high;
    reg next_low;
    reg next_stp;
    reg next_alarm_n;
    reg next_warning_n;

    assign pins_raw = {active_short_level_in, active_short_enable_in,
        pwm_negative_in, pwm_positive_in};

    assign pwm_p = sync_b[0];
    assign pwm_n = sync_b[1];
    assign active_short_enable = sync_b[2];
    assign asc_lvl = sync_b[3];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_sync
            // The first stage may go metastable, so only the second stage reads it.
            always @(posedge clk_in)
            begin
                if (srst_in)
                begin
                    sync_a[gi] <= SYNC_RST[gi];
                    sync_b[gi] <= SYNC_RST[gi];
                end
                else
                begin
                    sync_a[gi] <= pins_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    // Both drivers off when disabled and active short is off, so the gate is held by the passive pull-down.
    always @*
    begin
        next_high = 1'b0;
        next_low = 1'b0;
        if (active_short_enable)
        begin
            next_high = asc_lvl;
            next_low = ~asc_lvl;
        end
        else if (driver_enable_in)
        begin
            next_high = pwm_p;
            next_low = ~pwm_p;
        end
    end

    always @*
    begin
        next_stp = pwm_p & pwm_n;
    end

    // The shoot-through flag is one of the faults the indicators report.
    assign stp_vec = {{(FAULT_W-1){1'b0}}, shoot_through_fault_out} << `GDIC_STP_BIT;
    assign faults = fault_event_in | stp_vec;
    assign alarm_hits = faults & ~alarm_mask_in;
    assign warning_hits = faults & ~warning_mask_in;

    always @*
    begin
        next_alarm_n = ~|alarm_hits;
    end

    // The duty period is the full count range of the counter.
    assign duty_wrap = &duty_cnt;

    always @*
    begin
        next_duty_cnt = duty_cnt + DUTY_STEP;
    end

    // The ADC value is taken once per period so the duty never glitches mid-cycle.
    always @*
    begin
        next_duty_level = duty_level;
        if (duty_wrap)
        begin
            next_duty_level = adc_value_in;
        end
    end

    always @*
    begin
        if (duty_mode_in)
        begin
            next_warning_n = (duty_cnt < duty_level);
        end
        else
        begin
            next_warning_n = ~|warning_hits;
        end
    end

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            high_side_output_out <= `GDIC_HS_RST;
        end
        else
        begin
            high_side_output_out <= next_high;
        end
    end

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            low_side_output_out <= `GDIC_LS_RST;
        end
        else
        begin
            low_side_output_out <= next_low;
        end
    end

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            shoot_through_fault_out <= `GDIC_STP_RST;
        end
        else
        begin
            shoot_through_fault_out <= next_stp;
        end
    end

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            fault_alarm_n_out <= `GDIC_ALARM_RST;
        end
        else
        begin
            fault_alarm_n_out <= next_alarm_n;
        end
    end

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            fault_warning_n_out <= `GDIC_WARN_RST;
        end
        else
        begin
            fault_warning_n_out <= next_warning_n;
        end
    end

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            duty_cnt <= DUTY_ZERO;
        end
        else
        begin
            duty_cnt <= next_duty_cnt;
        end
    end

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            duty_level <= DUTY_ZERO;
        end
        else
        begin
            duty_level <= next_duty_level;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/gdic_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdic_monitor #(parameter FAULT_W = 8) (input wire clk_in, srst_in, pwm_positive_in,
    pwm_negative_in, active_short_enable_in, active_short_level_in, driver_enable_in,
    duty_mode_in, high_side_output_out, low_side_output_out, shoot_through_fault_out,
    fault_alarm_n_out, fault_warning_n_out,
    input wire [FAULT_W-1:0] fault_event_in, alarm_mask_in, warning_mask_in);
    // Checks wait until the pin pipeline has refilled after reset.
    logic [2:0] up;
    always @(posedge clk_in) up <= srst_in ? 3'h0 : up + {2'h0, up != 3'h5};
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_hs; up == 3'h5 |-> high_side_output_out == ($past(active_short_enable_in, 3) ?
        $past(active_short_level_in, 3) : $past(driver_enable_in) & $past(pwm_positive_in, 3));
    endproperty
    a_hs: assert property (p_hs) else $error("high side mismatch");
    property p_ls; up == 3'h5 |-> low_side_output_out == ($past(active_short_enable_in, 3) ?
        !$past(active_short_level_in, 3) : $past(driver_enable_in) & !$past(pwm_positive_in, 3));
    endproperty
    a_ls: assert property (p_ls) else $error("low side mismatch");
    property p_st; up == 3'h5 |-> shoot_through_fault_out ==
        ($past(pwm_positive_in, 3) & $past(pwm_negative_in, 3)); endproperty
    a_st: assert property (p_st) else $error("overlap flag mismatch");
    property p_al; up == 3'h5 |-> !fault_alarm_n_out ==
        |($past(fault_event_in | shoot_through_fault_out) & ~$past(alarm_mask_in)); endproperty
    a_al: assert property (p_al) else $error("alarm mismatch");
    property p_wn; up == 3'h5 && !$past(duty_mode_in) |-> !fault_warning_n_out ==
        |($past(fault_event_in | shoot_through_fault_out) & ~$past(warning_mask_in)); endproperty
    a_wn: assert property (p_wn) else $error("warning mismatch");
    property p_rst; $past(srst_in) |-> !high_side_output_out && low_side_output_out &&
        !shoot_through_fault_out && fault_alarm_n_out && fault_warning_n_out; endproperty
    a_rst: assert property (p_rst) else $error("reset state mismatch");
    c_asc: cover property (active_short_enable_in && high_side_output_out);
    c_stp: cover property ($rose(shoot_through_fault_out));
    c_duty: cover property (duty_mode_in && $fell(fault_warning_n_out));
endmodule
bind gdic_top gdic_monitor #(.FAULT_W(FAULT_W)) u_mon (.*);
`default_nettype wire

// ---- testbench/gdic_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module gdic_host (input wire logic clk_in, input wire logic srst_in, output logic pwm_out);
    // A 400-cycle period is 50 kHz at 20 MHz, the fastest rate the host may use.
    logic [8:0] phase;
    always @(posedge clk_in)
    begin
        phase <= (srst_in || phase == 9'h18F) ? 9'h000 : phase + 9'h001;
        pwm_out <= !srst_in && phase < 9'h0C8;
    end
endmodule
`default_nettype wire

// ---- testbench/gate_drive_input_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module gate_drive_input_control_bench;
    logic clk_in = 0, srst_in = 1, pwm_negative_in = 0, active_short_enable_in = 0;
    logic active_short_level_in = 0, driver_enable_in = 1, duty_mode_in = 0;
    logic [7:0] fault_event_in = 8'h00, alarm_mask_in = 8'h00, warning_mask_in = 8'h00;
    logic [9:0] adc_value_in = 10'h000;
    logic [11:0] n;
    wire pwm_positive_in, high_side_output_out, low_side_output_out, shoot_through_fault_out;
    wire fault_alarm_n_out, fault_warning_n_out;
    int num_errors = 0, checks = 0;
    gdic_top DUT (.*);
    gdic_host HOST (.clk_in, .srst_in, .pwm_out(pwm_positive_in));
    always #25 clk_in = ~clk_in;
    task automatic edges(input int k); repeat (k) @(posedge clk_in); endtask
    task automatic t_drive;
        @(posedge pwm_positive_in); edges(4);
        `CHK({high_side_output_out, low_side_output_out}, 2'h2)
        driver_enable_in <= 0; edges(2);
        `CHK({high_side_output_out, low_side_output_out}, 2'h0)
        driver_enable_in <= 1; @(negedge pwm_positive_in); edges(4);
        `CHK({high_side_output_out, low_side_output_out}, 2'h1)
    endtask
    task automatic t_asc;
        for (int lv = 0; lv < 2; lv++)
        begin
            active_short_enable_in <= 1; active_short_level_in <= lv[0]; edges(4);
            `CHK({high_side_output_out, low_side_output_out}, {lv[0], !lv[0]})
        end
        active_short_enable_in <= 0;
    endtask
    task automatic t_fault;
        pwm_negative_in <= 1; @(posedge pwm_positive_in); edges(5);
        `CHK({shoot_through_fault_out, fault_alarm_n_out}, 2'h2)
        alarm_mask_in <= 8'h01; edges(2);
        `CHK(fault_alarm_n_out, 1'h1)
        pwm_negative_in <= 0; fault_event_in <= 8'h80; edges(6);
        `CHK({fault_alarm_n_out, fault_warning_n_out}, 2'h0)
        warning_mask_in <= 8'h80; edges(2);
        `CHK(fault_warning_n_out, 1'h1)
    endtask
    task automatic t_duty;
        duty_mode_in <= 1; adc_value_in <= 10'h100; edges(1100); n = 12'h000;
        repeat (2048) begin @(posedge clk_in); n += fault_warning_n_out; end
        `CHK(n, 12'h200)
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        edges(16); srst_in <= 0; edges(6);
        t_drive; t_asc; t_fault; t_duty; summarize;
    end
    initial
    begin
        edges(20000); num_errors++; summarize;
    end
endmodule
`default_nettype wire
